// [link_ctrl_pkg.sv]
// Constants and types for the scanner host link controller
// Function
// - Failed USB setup falls back after programmed minutes
// - Fallback refuses decodes, beeps its own pattern
// - Fallback still applies menu symbols
// - Acknowledge wait timeout, default 2000 ms
// - Timeout retries, zero abandons on first
// - Timeout sounds error beep when enabled
// - Negative acknowledge resends, limited count
// - Bell beeps, cancel aborts transmission
// - Bell/cancel off by default, acknowledge only
// - First fuel preset: 1200, 8M1, flow, LF
// - Second fuel preset: 2400, 7E2, CR
// - In-house aux preset: 38400, 8N1, ack
// - Third-party aux preset: 9600, 7E1, flow
// - USB keyboards append CR and LF
// - USB serial emulation needs no framing
// - ALT sequences of 3 or 4 digits
package link_ctrl_pkg;
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned MS_NS         = 1_000_000;
    localparam int unsigned CLK_NS        = 25;
    localparam int unsigned MS_CYCLES     = MS_NS / CLK_NS;
    localparam int unsigned MIN_PER_MS    = 60_000;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_TIMING   = 8'h04;
    localparam logic [7:0] OFF_RETRY    = 8'h08;
    localparam logic [7:0] OFF_STATUS   = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFF_FORMAT   = 8'h18;
    // Control fields
    localparam int unsigned CTL_ACK_EN   = 0;
    localparam int unsigned CTL_BELCAN   = 1;
    localparam int unsigned CTL_TO_BEEP  = 2;
    localparam int unsigned CTL_ALT_EN   = 3;
    localparam int unsigned CTL_ALT4     = 4;
    localparam int unsigned CTL_IF_LSB   = 8;
    localparam int unsigned CTL_PRE_LSB  = 12;
    localparam int unsigned CTL_PRE_GO   = 15;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0004;
    localparam logic [15:0] ACK_TO_RESET = 16'h07D0;
    localparam logic [5:0]  FALLBACK_MIN_RESET = 6'h05;
    localparam logic [5:0]  FALLBACK_MIN_MAX   = 6'h3C;
    // Host interface kinds
    localparam logic [2:0] IF_SERIAL   = 3'h0;
    localparam logic [2:0] IF_USB_KB   = 3'h1;
    localparam logic [2:0] IF_USB_MAC  = 3'h2;
    localparam logic [2:0] IF_USB_CDC  = 3'h3;
    localparam logic [2:0] IF_USB_HID  = 3'h4;
    // Presets
    localparam logic [2:0] PRE_FUEL_A  = 3'h1;
    localparam logic [2:0] PRE_FUEL_B  = 3'h2;
    localparam logic [2:0] PRE_AUX_OWN = 3'h3;
    localparam logic [2:0] PRE_AUX_3RD = 3'h4;
    // Format word: baud[15:0] bits[16] par[19:17] stop[20] flow[23:21]
    //   suffix[25:24] (bit0 CR, bit1 LF)
    localparam logic [2:0] PAR_NONE = 3'h0;
    localparam logic [2:0] PAR_EVEN = 3'h1;
    localparam logic [2:0] PAR_MARK = 3'h3;
    localparam logic [2:0] FLOW_OFF    = 3'h0;
    localparam logic [2:0] FLOW_MSG_NT = 3'h1;
    localparam logic [2:0] FLOW_CHR_TO = 3'h2;
    localparam logic [2:0] FLOW_MSG_TO = 3'h3;
    localparam logic [31:0] FMT_RESET = 32'h0000_2580;
    localparam logic [31:0] FMT_FUEL_A =
        {6'h00, 2'h2, FLOW_MSG_NT, 1'b0, PAR_MARK, 1'b1, 16'h04B0};
    localparam logic [31:0] FMT_FUEL_B =
        {6'h00, 2'h1, FLOW_OFF, 1'b1, PAR_EVEN, 1'b0, 16'h0960};
    localparam logic [31:0] FMT_AUX_OWN =
        {6'h00, 2'h0, FLOW_CHR_TO, 1'b0, PAR_NONE, 1'b1, 16'h9600};
    localparam logic [31:0] FMT_AUX_3RD =
        {6'h00, 2'h0, FLOW_MSG_TO, 1'b0, PAR_EVEN, 1'b0, 16'h2580};
    // Host control characters
    localparam logic [7:0] CH_ACK = 8'h06;
    localparam logic [7:0] CH_NAK = 8'h15;
    localparam logic [7:0] CH_BEL = 8'h07;
    localparam logic [7:0] CH_CAN = 8'h18;
    // Interrupt bits
    localparam int unsigned IRQ_DONE     = 0;
    localparam int unsigned IRQ_ABANDON  = 1;
    localparam int unsigned IRQ_CANCEL   = 2;
    localparam int unsigned IRQ_FALLBACK = 3;
    localparam int unsigned IRQ_BITS     = 4;
    // Beep codes
    localparam logic [1:0] BEEP_ERROR    = 2'h1;
    localparam logic [1:0] BEEP_FALLBACK = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SEND = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_DONE = 4'b1000
    } ack_state_t;
endpackage

// [ms_tick.sv]
// Millisecond tick generator
`timescale 1ns/10ps
module ms_tick #(
    parameter int unsigned CYCLES = 40000
) (
    input  wire logic clk_in,
    input  wire logic reset_in,
    output logic      tick_out
);
    logic [31:0] count_r;

    always_ff @(posedge clk_in) begin
        if (reset_in || count_r == CYCLES - 1) begin
            count_r <= 32'h0000_0000;
        end else begin
            count_r <= count_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_in) begin
        tick_out <= !reset_in && count_r == CYCLES - 1;
    end
endmodule // ms_tick

// [link_ctrl.sv]
// Host link controller: acknowledge protocol, fallback, presets
`timescale 1ns/10ps
module link_ctrl #(
    parameter int unsigned MS_CYC = link_ctrl_pkg::MS_CYCLES
) (
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hsel_in,
    input  wire logic        hready_in,
    output logic [31:0]      hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire logic        usb_cfg_fail_in,
    input  wire logic        usb_configured_in,
    input  wire logic        decode_valid_in,
    input  wire logic        decode_menu_in,
    output logic             decode_accept_out,
    output logic             menu_apply_out,
    input  wire logic        msg_valid_in,
    output logic             msg_busy_out,
    output logic             msg_send_out,
    input  wire logic        rx_valid_in,
    input  wire logic [7:0]  rx_char_in,
    output logic             beep_out,
    output logic [1:0]       beep_kind_out,
    output logic [2:0]       host_if_out,
    output logic             cdc_no_framing_out,
    output logic [1:0]       suffix_out,
    output logic [2:0]       alt_digits_out,
    output logic [31:0]      format_out,
    output logic             irq_out
);
    import link_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////
    logic        tick;
    logic [31:0] ctrl_r;
    logic [31:0] fmt_r;
    logic [15:0] ack_to_r;
    logic [5:0]  fb_min_r;
    logic [7:0]  to_retry_r;
    logic [7:0]  nak_retry_r;
    logic [IRQ_BITS-1:0] irq_stat_r;
    logic [IRQ_BITS-1:0] irq_mask_r;
    logic [IRQ_BITS-1:0] ev;
    logic        fallback_r;
    logic [21:0] fb_ms_r;
    logic [15:0] wait_ms_r;
    logic [7:0]  to_cnt_r;
    logic [7:0]  nak_cnt_r;
    logic        rx_ack_r;
    logic        rx_nak_r;
    logic        rx_bel_r;
    logic        rx_can_r;
    ack_state_t  state_r;
    logic        dp_act_r;
    logic        dp_wr_r;
    logic [7:0]  dp_addr_r;
    logic        wr_go;
    logic        rd_go;
    logic [31:0] rd_val;

    ms_tick #(.CYCLES(MS_CYC)) u_tick (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .tick_out (tick)
    );

    ////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY
    assign wr_go = dp_act_r && dp_wr_r;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            dp_act_r  <= 1'b0;
            dp_wr_r   <= 1'b0;
            dp_addr_r <= 8'h00;
        end else if (hready_in) begin
            dp_act_r  <= hsel_in && htrans_in[1];
            dp_wr_r   <= hwrite_in;
            dp_addr_r <= haddr_in[7:0];
        end
    end

    assign rd_go = hsel_in && htrans_in[1] && hready_in && !hwrite_in;

    always_comb begin
        rd_val = 32'h0000_0000;
        if (haddr_in[7:0] == OFF_CTRL) begin
            rd_val = ctrl_r;
        end else if (haddr_in[7:0] == OFF_TIMING) begin
            rd_val = {10'h000, fb_min_r, ack_to_r};
        end else if (haddr_in[7:0] == OFF_RETRY) begin
            rd_val = {16'h0000, nak_retry_r, to_retry_r};
        end else if (haddr_in[7:0] == OFF_STATUS) begin
            rd_val = {4'h0, state_r, nak_cnt_r, to_cnt_r,
                      7'h00, fallback_r};
        end else if (haddr_in[7:0] == OFF_IRQ_STAT) begin
            rd_val = {28'h000_0000, irq_stat_r};
        end else if (haddr_in[7:0] == OFF_IRQ_MASK) begin
            rd_val = {28'h000_0000, irq_mask_r};
        end else if (haddr_in[7:0] == OFF_FORMAT) begin
            rd_val = fmt_r;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            hrdata_out <= 32'h0000_0000;
        end else if (rd_go) begin
            hrdata_out <= rd_val;
        end
    end

    always_ff @(posedge clk_in) begin
        hreadyout_out <= 1'b1;
        hresp_out     <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration registers; a preset write reloads the format word
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ctrl_r      <= CTRL_RESET;
            ack_to_r    <= ACK_TO_RESET;
            fb_min_r    <= FALLBACK_MIN_RESET;
            to_retry_r  <= 8'h00;
            nak_retry_r <= 8'h00;
            irq_mask_r  <= '0;
            fmt_r       <= FMT_RESET;
        end else if (wr_go) begin
            if (dp_addr_r == OFF_CTRL) begin
                ctrl_r <= hwdata_in & 32'h0000_FF1F;
                if (hwdata_in[CTL_PRE_GO]) begin
                    case (hwdata_in[CTL_PRE_LSB +: 3])
                        PRE_FUEL_A:  fmt_r <= FMT_FUEL_A;
                        PRE_FUEL_B:  fmt_r <= FMT_FUEL_B;
                        PRE_AUX_OWN: begin
                            fmt_r <= FMT_AUX_OWN;
                            ctrl_r[CTL_ACK_EN] <= 1'b1;
                        end
                        PRE_AUX_3RD: fmt_r <= FMT_AUX_3RD;
                        default:     fmt_r <= fmt_r;
                    endcase
                end
            end else if (dp_addr_r == OFF_TIMING) begin
                ack_to_r <= hwdata_in[15:0];
                if (hwdata_in[21:16] <= FALLBACK_MIN_MAX) begin
                    fb_min_r <= hwdata_in[21:16];
                end
            end else if (dp_addr_r == OFF_RETRY) begin
                to_retry_r  <= hwdata_in[7:0];
                nak_retry_r <= hwdata_in[15:8];
            end else if (dp_addr_r == OFF_IRQ_MASK) begin
                irq_mask_r <= hwdata_in[IRQ_BITS-1:0];
            end else if (dp_addr_r == OFF_FORMAT) begin
                fmt_r <= hwdata_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // USB fallback timer, counted in milliseconds
    always_ff @(posedge clk_in) begin
        if (reset_in || usb_configured_in || !usb_cfg_fail_in) begin
            fb_ms_r    <= '0;
            fallback_r <= 1'b0;
        end else if (!fallback_r) begin
            if (fb_ms_r >= 22'(fb_min_r * MIN_PER_MS)) begin
                fallback_r <= 1'b1;
            end else if (tick) begin
                fb_ms_r <= fb_ms_r + 22'h00_0001;
            end
        end
    end

    // Menu symbols pass in fallback, ordinary decodes are refused
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            decode_accept_out <= 1'b0;
            menu_apply_out    <= 1'b0;
        end else begin
            decode_accept_out <= decode_valid_in && !decode_menu_in
                                 && !fallback_r;
            menu_apply_out    <= decode_valid_in && decode_menu_in;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Host character decode; bell and cancel only in acknowledge mode
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rx_ack_r <= 1'b0;
            rx_nak_r <= 1'b0;
            rx_bel_r <= 1'b0;
            rx_can_r <= 1'b0;
        end else begin
            rx_ack_r <= rx_valid_in && rx_char_in == CH_ACK;
            rx_nak_r <= rx_valid_in && rx_char_in == CH_NAK;
            rx_bel_r <= rx_valid_in && rx_char_in == CH_BEL
                        && ctrl_r[CTL_BELCAN] && ctrl_r[CTL_ACK_EN];
            rx_can_r <= rx_valid_in && rx_char_in == CH_CAN
                        && ctrl_r[CTL_BELCAN] && ctrl_r[CTL_ACK_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Acknowledge state machine
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_r      <= ST_IDLE;
            wait_ms_r    <= '0;
            to_cnt_r     <= '0;
            nak_cnt_r    <= '0;
            msg_send_out <= 1'b0;
            ev           <= '0;
        end else begin
            msg_send_out <= 1'b0;
            ev           <= '0;
            case (state_r)
                ST_IDLE: begin
                    to_cnt_r  <= '0;
                    nak_cnt_r <= '0;
                    if (msg_valid_in) begin
                        state_r <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    msg_send_out <= 1'b1;
                    wait_ms_r    <= '0;
                    state_r      <= ctrl_r[CTL_ACK_EN] ? ST_WAIT : ST_DONE;
                end
                ST_WAIT: begin
                    if (rx_can_r) begin
                        ev[IRQ_CANCEL] <= 1'b1;
                        state_r        <= ST_IDLE;
                    end else if (rx_ack_r) begin
                        state_r <= ST_DONE;
                    end else if (rx_nak_r) begin
                        if (nak_cnt_r < nak_retry_r) begin
                            nak_cnt_r <= nak_cnt_r + 8'h01;
                            state_r   <= ST_SEND;
                        end else begin
                            ev[IRQ_ABANDON] <= 1'b1;
                            state_r         <= ST_IDLE;
                        end
                    end else if (wait_ms_r >= ack_to_r) begin
                        if (to_cnt_r < to_retry_r) begin
                            to_cnt_r <= to_cnt_r + 8'h01;
                            state_r  <= ST_SEND;
                        end else begin
                            ev[IRQ_ABANDON] <= 1'b1;
                            state_r         <= ST_IDLE;
                        end
                    end else if (tick) begin
                        wait_ms_r <= wait_ms_r + 16'h0001;
                    end
                end
                ST_DONE: begin
                    ev[IRQ_DONE] <= 1'b1;
                    state_r      <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        msg_busy_out <= !reset_in && state_r != ST_IDLE;
    end

    ////////////////////////////////////////////////////////////////////
    // Beeper: timeout error, bell error, fallback pattern
    logic fb_d_r;
    logic to_hit;
    assign to_hit = state_r == ST_WAIT && !rx_can_r && !rx_ack_r
                    && !rx_nak_r && wait_ms_r >= ack_to_r;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            fb_d_r        <= 1'b0;
            beep_out      <= 1'b0;
            beep_kind_out <= 2'h0;
        end else begin
            fb_d_r        <= fallback_r;
            beep_out      <= 1'b0;
            beep_kind_out <= 2'h0;
            if ((to_hit && ctrl_r[CTL_TO_BEEP]) || rx_bel_r) begin
                beep_out      <= 1'b1;
                beep_kind_out <= BEEP_ERROR;
            end else if ((fallback_r && !fb_d_r)
                         || (fallback_r && decode_valid_in
                             && !decode_menu_in)) begin
                beep_out      <= 1'b1;
                beep_kind_out <= BEEP_FALLBACK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interface outputs; fallback forces only host_if_out to the keyboard class
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            host_if_out        <= IF_SERIAL;
            cdc_no_framing_out <= 1'b0;
            suffix_out         <= 2'h0;
            alt_digits_out     <= 3'h0;
            format_out         <= FMT_RESET;
        end else begin
            host_if_out <= fallback_r ? IF_USB_KB
                                      : ctrl_r[CTL_IF_LSB +: 3];
            cdc_no_framing_out <= ctrl_r[CTL_IF_LSB +: 3]
                                  == IF_USB_CDC;
            if (ctrl_r[CTL_IF_LSB +: 3] == IF_USB_KB
                || ctrl_r[CTL_IF_LSB +: 3] == IF_USB_MAC) begin
                suffix_out <= 2'h3;
            end else begin
                suffix_out <= fmt_r[25:24];
            end
            alt_digits_out <= !ctrl_r[CTL_ALT_EN] ? 3'h0
                              : ctrl_r[CTL_ALT4] ? 3'h4 : 3'h3;
            format_out <= fmt_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sticky interrupts; a new event wins over a write-one clear
    logic ev_fb;
    assign ev_fb = fallback_r && !fb_d_r;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            irq_stat_r <= '0;
            irq_out    <= 1'b0;
        end else begin
            for (int i = 0; i < IRQ_BITS; i++) begin
                if (ev[i] || (i == IRQ_FALLBACK && ev_fb)) begin
                    irq_stat_r[i] <= 1'b1;
                end else if (wr_go && dp_addr_r == OFF_IRQ_STAT
                             && hwdata_in[i]) begin
                    irq_stat_r[i] <= 1'b0;
                end
            end
            irq_out <= |(irq_stat_r & irq_mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////
    a_fallback_refuse: assert property (@(posedge clk_in) disable iff
        (reset_in) fallback_r |=> !decode_accept_out)
        else $error("decode accepted in fallback");
    a_menu_passes: assert property (@(posedge clk_in) disable iff
        (reset_in) decode_valid_in && decode_menu_in |=> menu_apply_out)
        else $error("menu symbol not applied");
    a_nak_limit: assert property (@(posedge clk_in) disable iff
        (reset_in) nak_cnt_r <= nak_retry_r || $changed(nak_retry_r)
        || $past(wr_go))
        else $error("nak resends over limit");
    a_timeout_abandon: assert property (@(posedge clk_in) disable iff
        (reset_in) to_hit && to_cnt_r >= to_retry_r
        |=> state_r == ST_IDLE ##0 ev[IRQ_ABANDON])
        else $error("timeout did not abandon");
    a_timeout_beep: assert property (@(posedge clk_in) disable iff
        (reset_in) to_hit && ctrl_r[CTL_TO_BEEP]
        |=> beep_out && beep_kind_out == BEEP_ERROR)
        else $error("no error beep on timeout");
    a_cancel_abort: assert property (@(posedge clk_in) disable iff
        (reset_in) state_r == ST_WAIT && rx_can_r
        |=> state_r == ST_IDLE)
        else $error("cancel did not abort");
    a_belcan_gate: assert property (@(posedge clk_in) disable iff
        (reset_in) !ctrl_r[CTL_ACK_EN] || !ctrl_r[CTL_BELCAN]
        |=> !rx_can_r && !rx_bel_r)
        else $error("bell or cancel honoured while off");
    a_kb_suffix: assert property (@(posedge clk_in) disable iff
        (reset_in) ctrl_r[CTL_IF_LSB +: 3] == IF_USB_KB
        |=> suffix_out == 2'h3)
        else $error("keyboard suffix missing");
endmodule // link_ctrl

// [host_term.sv]
// Host terminal model answering each transmitted message unless its reply is 00
`timescale 1ns/10ps
module host_term (
    input  wire logic       clk_in,
    input  wire logic       send_in,
    input  wire logic [7:0] reply_in,
    output logic            rx_valid_out,
    output logic [7:0]      rx_char_out
);
    logic [1:0] dly_r = 2'h0;
    initial rx_valid_out = 1'b0;
    initial rx_char_out = 8'h00;
    // Reply 00 stays silent; idle char toggles so nothing stale lingers
    always @(posedge clk_in) begin
        dly_r <= {dly_r[0], send_in && reply_in != 8'h00};
        rx_valid_out <= dly_r[1];
        rx_char_out <= dly_r[1] ? reply_in : ~rx_char_out;
    end
endmodule // host_term

// [testbench.sv]
// Self-checking testbench for the host link controller
`timescale 1ns/10ps
module testbench;
    import link_ctrl_pkg::*;
    logic        clk_in = 1'b0, reset_in = 1'b1, hwrite = 1'b0;
    logic        hsel = 1'b0, fail = 1'b0, dv = 1'b0, dm = 1'b0, mv = 1'b0;
    logic        hrdy, hresp, dacc, mapp, busy, send, rxv, beep, cdc, irq;
    logic [1:0]  htrans = 2'h0, bkind, suf;
    logic [2:0]  hif, alt;
    logic [7:0]  reply = 8'h00, rxc;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, fmt, rd;
    int          miscompares = 0, n_checks = 0, cyc = 0;
    int          sends = 0, errs = 0, fbs = 0;
    always #12.5 clk_in = ~clk_in;
    link_ctrl #(.MS_CYC(4)) dut (
        .clk_in(clk_in), .reset_in(reset_in), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hsel_in(hsel), .hready_in(hrdy),
        .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
        .usb_cfg_fail_in(fail), .usb_configured_in(1'b0),
        .decode_valid_in(dv), .decode_menu_in(dm), .decode_accept_out(dacc),
        .menu_apply_out(mapp), .msg_valid_in(mv), .msg_busy_out(busy),
        .msg_send_out(send), .rx_valid_in(rxv), .rx_char_in(rxc),
        .beep_out(beep), .beep_kind_out(bkind), .host_if_out(hif),
        .cdc_no_framing_out(cdc), .suffix_out(suf), .alt_digits_out(alt),
        .format_out(fmt), .irq_out(irq));
    host_term host (.clk_in(clk_in), .send_in(send), .reply_in(reply),
        .rx_valid_out(rxv), .rx_char_out(rxc));
    ////////////////////////////////////////
    // Event counters; the watchdog sits far above the expected run
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        sends <= sends + send;
        errs <= errs + (beep && bkind === BEEP_ERROR);
        fbs <= fbs + (beep && bkind === BEEP_FALLBACK);
        if (cyc == 20000) begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (miscompares == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic ck(input string what, input logic [31:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Idle cycles after each transfer let registered outputs settle
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do @(posedge clk_in); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk_in); while (hrdy !== 1'b1);
        rd = hrdata;
        repeat (2) @(posedge clk_in);
    endtask
    task automatic rk(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        ck(what, exp, rd);
    endtask
    task automatic msg(input logic [7:0] r, input int n, e,
                       input logic [31:0] st);
        int s0, e0;
        s0 = sends;
        e0 = errs;
        reply <= r;
        mv <= 1'b1;
        do @(posedge clk_in); while (busy !== 1'b1);
        mv <= 1'b0;
        do @(posedge clk_in); while (busy === 1'b1);
        repeat (3) @(posedge clk_in);
        ck("sends", n, sends - s0);
        ck("error beeps", e, errs - e0);
        rk("irq status", OFF_IRQ_STAT, st);
        bus(1'b1, OFF_IRQ_STAT, 32'hF);
    endtask
    task automatic pulse(input logic m);
        dv <= 1'b1;
        dm <= m;
        @(posedge clk_in);
        dv <= 1'b0;
        @(posedge clk_in);
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        rk("ctrl", OFF_CTRL, CTRL_RESET);
        rk("timing", OFF_TIMING, 32'h0005_07D0);
        rk("retry", OFF_RETRY, 32'h0);
        rk("unmapped", 8'h1C, 32'h0);
        ck("hresp", 32'h0, hresp);
        ck("alt", 32'h0, alt);
        pulse(1'b0);
        ck("accepted", 32'h1, dacc);
    endtask
    task automatic t_setup();
        logic [31:0] tbl [4] = '{FMT_FUEL_A, FMT_FUEL_B, FMT_AUX_OWN,
                                 FMT_AUX_3RD};
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, OFF_CTRL, 32'h8000 | (32'(i + 1) << CTL_PRE_LSB));
            ck("format", tbl[i], fmt);
            ck("suffix", tbl[i][25:24], suf);
            if (i == 2) rk("aux ack", OFF_CTRL, 32'hB001);
        end
        bus(1'b1, OFF_CTRL, 32'h100);
        ck("kb suffix", 32'h3, suf);
        bus(1'b1, OFF_CTRL, 32'h200);
        ck("mac suffix", 32'h3, suf);
        ck("interface", 32'h2, hif);
        bus(1'b1, OFF_CTRL, 32'h300);
        ck("no framing", 32'h1, cdc);
        bus(1'b1, OFF_CTRL, 32'h8);
        ck("alt 3", 32'h3, alt);
        bus(1'b1, OFF_CTRL, 32'h18);
        ck("alt 4", 32'h4, alt);
    endtask
    // One timeout retry, two NAK retries, 2 ms wait
    task automatic t_ack();
        bus(1'b1, OFF_TIMING, 32'h0005_0002);
        bus(1'b1, OFF_RETRY, 32'h0000_0201);
        bus(1'b1, OFF_CTRL, 32'h5);
        msg(CH_ACK, 1, 0, 32'h1);
        msg(CH_NAK, 3, 0, 32'h2);
        msg(8'h00, 2, 2, 32'h2);
        msg(CH_CAN, 2, 2, 32'h2);
        bus(1'b1, OFF_CTRL, 32'h7);
        msg(CH_CAN, 1, 0, 32'h4);
        msg(CH_BEL, 2, 4, 32'h2);
        bus(1'b1, OFF_RETRY, 32'h0);
        bus(1'b1, OFF_CTRL, 32'h1);
        msg(8'h00, 1, 0, 32'h2);
    endtask
    task automatic t_fallback();
        bus(1'b1, OFF_TIMING, 32'h0);
        fail <= 1'b1;
        do @(posedge clk_in); while (hif !== IF_USB_KB);
        bus(1'b0, OFF_STATUS, 32'h0);
        ck("fallback", 32'h1, rd[0]);
        ck("fb beep", 32'h1, fbs > 0);
        // A set mask bit lets its status bit reach the interrupt
        ck("irq masked", 32'h0, irq);
        bus(1'b1, OFF_IRQ_MASK, 32'h8);
        ck("irq set", 32'h1, irq);
        bus(1'b1, OFF_IRQ_STAT, 32'h8);
        ck("irq clear", 32'h0, irq);
        bus(1'b1, OFF_IRQ_MASK, 32'h0);
        pulse(1'b0);
        ck("refused", 32'h0, dacc);
        pulse(1'b1);
        ck("menu", 32'h1, mapp);
    endtask
    initial begin
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        t_reset();
        t_setup();
        t_ack();
        t_fallback();
        give_verdict();
    end
endmodule // testbench
